// [design/hpc_defines.vh]
// constants for the host port pin control block
`ifndef HPC_DEFINES_VH
`define HPC_DEFINES_VH
// address map on the 7-bit word address (A[7:1])
`define HPC_ADDR_W 7
`define HPC_DATA_W 16
// word addresses below this go to the fifos, at or above to the csr space
`define HPC_CSR_BASE 7'h28
// within the fifo window, A[2] picks tx (1) or rx (0)
`define HPC_FIFO_DIR_BIT 1
// pin function select for the eeprom pins
`define HPC_PF_EEPROM 2'h0
`define HPC_PF_GPO 2'h1
`define HPC_PF_MON_A 2'h2
`define HPC_PF_MON_B 2'h3
// irq drive type
`define HPC_IRQ_PUSH_PULL 1'b0
`define HPC_IRQ_OPEN_DRAIN 1'b1
// strap defaults: speed 1 = 100 Mb/s, duplex 0 = half
`define HPC_SPEED_10 1'b0
`define HPC_SPEED_100 1'b1
`define HPC_DUPLEX_HALF 1'b0
`endif

// [design/hpc_sync.v]
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module hpc_sync #(
	parameter WIDTH = 3,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire clk,
	input wire reset_n,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;
	// first stage is read only by the second stage
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // hpc_sync

// [design/hpc_top.v]
// host port pin control: strobe decode, irq pin, straps, crossover, eeprom pin mux
`timescale 1ns/1ps
`include "hpc_defines.vh"
// Notes on behaviour
// R01: decode 7-bit word address into csr or fifos
// R02: drive data bus only during qualified reads
// R03: capture data bus on qualified write
// R04: strobes ignored without chip select
// R05: wake only on write with chip select
// R06: irq polarity, source and drive programmable
// R07: fifo select forces fifo access, ignores A[7:3]
// R08: strap 0 gives 10M half, no autoneg
// R09: strap 1 gives 100M half, autoneg on
// R10: swap pairs on auto or manual reversal
// R11: eeprom data pin: eeprom, general_output_three or tx monitor
// R12: eeprom clock pin: eeprom, general_output_four or rx monitor
// R13: eeprom select off when pins repurposed
// R14: repurposed pins are output only
// R15: speed strap sampled once at reset release
// R16: host reads once before writing
// R17: strobes synchronised, one access per strobe
module hpc_top #(
	parameter ADDR_W = `HPC_ADDR_W,
	parameter DATA_W = `HPC_DATA_W
) (
	input wire clk,
	input wire reset_n,
	input wire [ADDR_W-1:0] host_addr,
	input wire [DATA_W-1:0] host_data_in,
	output reg [DATA_W-1:0] host_data_out,
	output reg host_data_oe,
	input wire read_strobe_n,
	input wire write_strobe_n,
	input wire chip_select_n,
	input wire fifo_select,
	output reg acc_rd_r,
	output reg acc_wr_r,
	output reg acc_csr_r,
	output reg acc_fifo_tx_r,
	output reg [ADDR_W-1:0] acc_addr_r,
	output reg [DATA_W-1:0] acc_wdata_r,
	input wire [DATA_W-1:0] acc_rdata,
	input wire low_power,
	output reg wake_r,
	input wire [7:0] irq_sources,
	input wire [7:0] irq_enable,
	input wire irq_active_high,
	input wire irq_open_drain,
	output reg irq_out,
	output reg irq_oe,
	input wire speed_strap,
	output reg link_speed_100_r,
	output reg link_full_duplex_r,
	output reg link_autoneg_r,
	input wire auto_crossover_en,
	input wire reversed_detected,
	input wire manual_reverse,
	output reg pairs_swapped_r,
	input wire [1:0] data_pin_func,
	input wire [1:0] clock_pin_func,
	input wire general_output_three,
	input wire general_output_four,
	input wire mii_tx_en,
	input wire mii_tx_clk,
	input wire mii_rx_dv,
	input wire mii_rx_clk,
	input wire ee_cs_req,
	input wire ee_clk_req,
	input wire ee_do_req,
	input wire ee_do_oe_req,
	input wire eeprom_serial_data_in,
	output reg eeprom_serial_data_out,
	output reg eeprom_serial_data_oe,
	output reg eeprom_serial_clock,
	output reg eeprom_select,
	output reg eeprom_data_in_r
);
	// ============================================================
	// strobe synchronisation
	wire [2:0] strb_s;
	reg rd_q_r;
	reg wr_q_r;
	reg strap_done_r;
	wire rd_q;
	wire wr_q;
	wire pins_repurposed;
	hpc_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({read_strobe_n, write_strobe_n, chip_select_n}),
		.sync_out(strb_s)
	); // R17
	assign rd_q = ~strb_s[2] & ~strb_s[0]; // R04
	assign wr_q = ~strb_s[1] & ~strb_s[0]; // R04
	assign pins_repurposed = (data_pin_func != `HPC_PF_EEPROM) ||
		(clock_pin_func != `HPC_PF_EEPROM);

	// true when fifo select is low and the word address falls in the csr space
	function is_csr;
		input [ADDR_W-1:0] a;
		input fsel;
		begin
			is_csr = ~fsel & (a >= `HPC_CSR_BASE); // R07
		end
	endfunction

	// ============================================================
	// access decode
	// address and data are sampled with the strobe edge; the host holds them
	// stable across the strobe so two cycles of skew are harmless
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q_r <= 1'b0;
			wr_q_r <= 1'b0;
			acc_rd_r <= 1'b0;
			acc_wr_r <= 1'b0;
			acc_csr_r <= 1'b0;
			acc_fifo_tx_r <= 1'b0;
			acc_addr_r <= {ADDR_W{1'b0}};
			acc_wdata_r <= {DATA_W{1'b0}};
			wake_r <= 1'b0;
		end else begin
			rd_q_r <= rd_q;
			wr_q_r <= wr_q;
			acc_rd_r <= rd_q & ~rd_q_r; // R17
			acc_wr_r <= wr_q & ~wr_q_r; // R17
			wake_r <= low_power & wr_q & ~wr_q_r; // R05
			if ((rd_q & ~rd_q_r) | (wr_q & ~wr_q_r)) begin
				acc_csr_r <= is_csr(host_addr, fifo_select); // R01
				acc_fifo_tx_r <= host_addr[`HPC_FIFO_DIR_BIT]; // R07
				acc_addr_r <= fifo_select ?
					{{(ADDR_W-2){1'b0}}, host_addr[1:0]} : host_addr; // R07
			end
			if (wr_q & ~wr_q_r) begin
				acc_wdata_r <= host_data_in; // R03
			end
		end
	end

	// ============================================================
	// read data drive
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			host_data_out <= {DATA_W{1'b0}};
			host_data_oe <= 1'b0;
		end else begin
			// the raw pins cut the drive one edge after release, so a write that
			// follows two cycles later never meets our driver on the bus
			host_data_oe <= rd_q & ~read_strobe_n & ~chip_select_n; // R02
			if (rd_q) begin
				host_data_out <= acc_rdata; // R02
			end
		end
	end

	// ============================================================
	// interrupt pin
	// open drain only pulls to the active level; it floats otherwise
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
		end else begin
			irq_out <= (|(irq_sources & irq_enable)) ~^ irq_active_high; // R06
			if (irq_open_drain == `HPC_IRQ_OPEN_DRAIN) begin
				irq_oe <= |(irq_sources & irq_enable); // R06
			end else begin
				irq_oe <= 1'b1; // R06
			end
		end
	end

	// ============================================================
	// speed strap and link defaults
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_done_r <= 1'b0;
			link_speed_100_r <= `HPC_SPEED_10;
			link_full_duplex_r <= `HPC_DUPLEX_HALF;
			link_autoneg_r <= 1'b0;
		end else if (!strap_done_r) begin
			// first edge after release catches the strap, then it is frozen
			strap_done_r <= 1'b1; // R15
			link_speed_100_r <= speed_strap ? `HPC_SPEED_100 : `HPC_SPEED_10; // R08 R09
			link_full_duplex_r <= `HPC_DUPLEX_HALF; // R08 R09
			link_autoneg_r <= speed_strap; // R08 R09
		end
	end

	// ============================================================
	// crossover
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pairs_swapped_r <= 1'b0;
		end else begin
			pairs_swapped_r <= manual_reverse | (auto_crossover_en & reversed_detected); // R10
		end
	end

	// ============================================================
	// eeprom pin multiplexing
	// monitor paths add one register stage, so mii clocks appear delayed
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			eeprom_serial_data_out <= 1'b0;
			eeprom_serial_data_oe <= 1'b0;
			eeprom_serial_clock <= 1'b0;
			eeprom_select <= 1'b0;
			eeprom_data_in_r <= 1'b0;
		end else begin
			eeprom_select <= pins_repurposed ? 1'b0 : ee_cs_req; // R13
			eeprom_data_in_r <= (data_pin_func == `HPC_PF_EEPROM) ?
				eeprom_serial_data_in : 1'b0; // R14
			case (data_pin_func)
				`HPC_PF_EEPROM: begin
					eeprom_serial_data_out <= ee_do_req; // R11
					eeprom_serial_data_oe <= ee_do_oe_req; // R11
				end
				`HPC_PF_GPO: begin
					eeprom_serial_data_out <= general_output_three; // R11
					eeprom_serial_data_oe <= 1'b1; // R14
				end
				`HPC_PF_MON_A: begin
					eeprom_serial_data_out <= mii_tx_en; // R11
					eeprom_serial_data_oe <= 1'b1; // R14
				end
				default: begin
					eeprom_serial_data_out <= mii_tx_clk; // R11
					eeprom_serial_data_oe <= 1'b1; // R14
				end
			endcase
			case (clock_pin_func)
				`HPC_PF_EEPROM: eeprom_serial_clock <= ee_clk_req; // R12
				`HPC_PF_GPO: eeprom_serial_clock <= general_output_four; // R12
				`HPC_PF_MON_A: eeprom_serial_clock <= mii_rx_dv; // R12
				default: eeprom_serial_clock <= mii_rx_clk; // R12
			endcase
		end
	end
endmodule // hpc_top

// [dv/hpc_checker.sv]
// concurrent checks on the host port pin control ports
`timescale 1ns/1ps
`include "hpc_defines.vh"
module hpc_checker (
	input logic clk,
	input logic reset_n,
	input logic read_strobe_n,
	input logic write_strobe_n,
	input logic chip_select_n,
	input logic fifo_select,
	input logic acc_rd_r,
	input logic acc_wr_r,
	input logic acc_csr_r,
	input logic low_power,
	input logic wake_r,
	input logic eeprom_select,
	input logic link_speed_100_r,
	input logic link_full_duplex_r,
	input logic link_autoneg_r,
	input logic [1:0] data_pin_func,
	input logic [1:0] clock_pin_func,
	input logic [6:0] host_addr,
	input logic [6:0] acc_addr_r,
	input logic [15:0] host_data_in,
	input logic [15:0] acc_wdata_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire acc = acc_rd_r || acc_wr_r;
	// the host lowers select and strobe together
	sequence s_rd; $fell(chip_select_n) && !read_strobe_n; endsequence
	sequence s_wr; $fell(chip_select_n) && !write_strobe_n; endsequence
	AST_RD_LAT: assert property (s_rd |-> ##[1:3] acc_rd_r)
		else $error("read access late");
	AST_WR_LAT: assert property (s_wr |->
		##[1:3] acc_wr_r && acc_wdata_r == $past(host_data_in, 2))
		else $error("write access late or wrong data");
	AST_ONE: assert property (acc |=> !acc_rd_r && !acc_wr_r)
		else $error("held strobe gave two accesses");
	AST_CS: assert property (acc |-> !$past(chip_select_n, 2))
		else $error("access without select");
	AST_DEC: assert property (acc && !$past(fifo_select, 2) |->
		acc_addr_r == $past(host_addr, 2) && acc_csr_r == (acc_addr_r >= `HPC_CSR_BASE))
		else $error("bad decode");
	AST_FIFO: assert property (acc && $past(fifo_select, 2) |-> !acc_csr_r && acc_addr_r[6:2] == 5'h00)
		else $error("fifo select not forced");
	AST_WAKE: assert property (wake_r || acc_wr_r |-> acc_wr_r && wake_r == $past(low_power))
		else $error("bad wake");
	AST_EE: assert property (data_pin_func != 2'h0 || clock_pin_func != 2'h0 |=> !eeprom_select)
		else $error("eeprom selected while pins repurposed");
	// straps are caught at the first edge after release, so stability is only
	// looked for once two edges have passed out of reset
	AST_STRAP: assert property ($past(reset_n) && $past(reset_n, 2) |->
		$stable(link_speed_100_r) && link_autoneg_r == link_speed_100_r && !link_full_duplex_r)
		else $error("bad link defaults");
endmodule // hpc_checker
bind hpc_top hpc_checker u_chk (.*);

// [dv/hpc_host_model.sv]
// host processor model on the sram-like strobes
`timescale 1ns/1ps
module hpc_host_model (
	input logic clk,
	input logic host_data_oe,
	input logic [15:0] host_data_out,
	output logic read_strobe_n = 1'h1,
	output logic write_strobe_n = 1'h1,
	output logic chip_select_n = 1'h1,
	output logic fifo_select = 1'h0,
	output logic [6:0] host_addr = 7'h00,
	output logic [15:0] host_data_in = 16'h0000
);
	// no ready pin, so the strobe is held long enough to cover the sync delay
	task automatic xfer(input logic w, cs, fs, input logic [6:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clk);
		host_addr = a;
		fifo_select = fs;
		host_data_in = d;
		chip_select_n = !cs;
		read_strobe_n = w;
		write_strobe_n = !w;
		repeat (6) @(posedge clk);
		q = host_data_oe ? host_data_out : 16'hDEAD;
		@(negedge clk);
		{read_strobe_n, write_strobe_n, chip_select_n} = 3'h7;
		host_data_in = ~d;
		repeat (3) @(negedge clk);
	endtask
endmodule // hpc_host_model

// [dv/hpc_top_bench.sv]
// self-checking bench for the host port pin control block
`timescale 1ns/1ps
module hpc_top_bench;
	logic clk = 1'h0, reset_n, low_power = 1'h0, speed_strap, irq_active_high, irq_open_drain;
	logic auto_crossover_en, reversed_detected, manual_reverse, ee_cs_req, ee_clk_req, ee_do_req;
	logic general_output_three, general_output_four, mii_tx_en, mii_tx_clk, mii_rx_dv;
	logic mii_rx_clk, ee_do_oe_req, eeprom_serial_data_in, host_data_oe, acc_rd_r, acc_wr_r;
	logic acc_csr_r, acc_fifo_tx_r, wake_r, irq_out, irq_oe, link_speed_100_r;
	logic link_full_duplex_r, link_autoneg_r, pairs_swapped_r, eeprom_serial_data_out;
	logic eeprom_serial_data_oe, eeprom_serial_clock, eeprom_select, eeprom_data_in_r;
	logic read_strobe_n, write_strobe_n, chip_select_n, fifo_select;
	logic [1:0] data_pin_func = 2'h0, clock_pin_func = 2'h0;
	logic [6:0] host_addr, acc_addr_r;
	logic [7:0] irq_sources = 8'h11, irq_enable = 8'h00;
	logic [15:0] host_data_in, host_data_out, acc_wdata_r, q, acc_rdata = 16'hA5C3;
	int num_errors = 0, check_count = 0;
	int rd_cnt = 0, wr_cnt = 0, wake_cnt = 0;
	// pulses are counted on the falling edge, where they have settled
	always @(negedge clk) begin
		rd_cnt <= rd_cnt + acc_rd_r;
		wr_cnt <= wr_cnt + acc_wr_r;
		wake_cnt <= wake_cnt + wake_r;
	end
	hpc_top u_dut (.*);
	hpc_host_model u_host (.*);
	initial forever #2.5 clk = ~clk;
	initial begin
		#100us;
		num_errors++;
		conclude;
	end
	task automatic chk(input string n, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{irq_active_high, irq_open_drain, auto_crossover_en, reversed_detected} = 4'h0;
		{manual_reverse, general_output_three, general_output_four, mii_tx_en} = 4'h0;
		{mii_tx_clk, mii_rx_dv, mii_rx_clk, ee_cs_req, ee_clk_req, ee_do_req} = 6'h00;
		{ee_do_oe_req, eeprom_serial_data_in} = 2'h0;
		for (int s = 1; s >= 0; s--) begin
			reset_n = 1'h0;
			speed_strap = s[0];
			repeat (16) @(negedge clk);
			reset_n = 1'h1;
			@(negedge clk);
			speed_strap = !s[0];
			repeat (2) @(negedge clk);
			chk("speed", s, link_speed_100_r);
			chk("autoneg", s, link_autoneg_r);
			chk("duplex", 16'h0000, link_full_duplex_r);
		end
		u_host.xfer(0, 1, 0, 7'h28, 16'h0000, q);
		chk("rdata", 16'hA5C3, q);
		chk("csr", 1, acc_csr_r);
		u_host.xfer(0, 1, 0, 7'h27, 16'h0000, q);
		chk("fifo", 0, acc_csr_r);
		low_power = 1'h1;
		u_host.xfer(1, 1, 1, 7'h7F, 16'h1234, q);
		chk("faddr", 7'h03, acc_addr_r);
		chk("tx", 1, acc_fifo_tx_r);
		chk("wdata", 16'h1234, acc_wdata_r);
		chk("wr_cnt", 1, wr_cnt);
		chk("wake", 1, wake_cnt);
		u_host.xfer(1, 0, 0, 7'h30, 16'h5678, q);
		chk("nocs_wr", 16'h1234, acc_wdata_r);
		u_host.xfer(0, 0, 0, 7'h30, 16'h0000, q);
		chk("nocs_rd", 16'hDEAD, q);
		u_host.xfer(0, 1, 1, 7'h7C, 16'h0000, q);
		chk("frdata", 16'hA5C3, q);
		chk("oe_off", 0, host_data_oe);
		chk("fcsr", 0, acc_csr_r);
		chk("rx", 0, acc_fifo_tx_r);
		chk("faddr_rd", 7'h00, acc_addr_r);
		chk("rd_cnt", 3, rd_cnt);
		chk("wr_cnt_end", 1, wr_cnt);
		chk("wake_end", 1, wake_cnt);
		for (int i = 0; i < 8; i++) begin
			{irq_open_drain, irq_active_high, irq_enable[4]} = i[2:0];
			{auto_crossover_en, reversed_detected, manual_reverse} = i[2:0];
			repeat (2) @(negedge clk);
			chk("irq_oe", !i[2] || i[0], irq_oe);
			chk("irq_out", i[0] ? i[1] : !i[1], irq_out);
			chk("swap", i[0] || i[2] && i[1], pairs_swapped_r);
		end
		// second pass flips every source so a stuck mux shows
		for (int f = 0; f < 8; f++) begin
			{mii_tx_clk, mii_tx_en, general_output_three, ee_do_req} = f[2] ? 4'h5 : 4'hA;
			{mii_rx_clk, mii_rx_dv, general_output_four, ee_clk_req} = f[2] ? 4'hA : 4'h5;
			{ee_cs_req, ee_do_oe_req, eeprom_serial_data_in} = {f[2], !f[2], f[2]};
			{data_pin_func, clock_pin_func} = {2{f[1:0]}};
			repeat (2) @(negedge clk);
			chk("ee_dout", f[0] ^ f[2], eeprom_serial_data_out);
			chk("ee_clk", !(f[0] ^ f[2]), eeprom_serial_clock);
			chk("ee_oe", f[1:0] != 0 || !f[2], eeprom_serial_data_oe);
			chk("ee_cs", f[1:0] == 0 && f[2], eeprom_select);
			chk("ee_din", f[1:0] == 0 && f[2], eeprom_data_in_r);
		end
		conclude;
	end
endmodule // hpc_top_bench
